// file: rtl/pcts_channel.sv
// one channel of pulse decimation, run statistics and coincidence validation
// Notes on behaviour
// R1: average 2^n adc samples for filter range n before energy filtering
// R2: rise plus flat top limited to 127 decimated cycles
// R3: fast variants: 20 ns granularity in range 1, min rise 2, flat 3 steps
// R4: 250 MHz variant: 16 ns granularity range 1, same minimum step counts
// R5: adc sample period is 2, 4 or 10 ns depending on variant
// R6: active time counts from setup done until end of run
// R7: active time pauses while adc input is out of range
// R8: trigger count increments once per fast threshold crossing; the code does not count crossings while adc_out_of_range is set
// R9: trigger count cleared at every run start
// R10: acquisition time counts run time, excluding start initialization
// R11: processed event count counts written events, cleared at run start
// R12: fast trigger shared after programmable delay, stretched to programmable length
// R13: local trigger delayed by programmable local processing delay
// R14: central logic masks shared triggers per channel (far side)
// R15: central logic forms and returns coincidence result (far side)
// R16: coincidence result opens validation window, driven onto probe
// R17: with validation required, accept only delayed trigger inside window
// R18: acceptance pulses on probe; delayed trigger on its own probe
// R19: require_coincidence_validation is control word bit 13
// R20: fast trigger by comparing fast filter output to fast_trigger_level
// R21: counters never wrap in a run and read without disturbing counting
// R22: decimated clock enable once per 2^n samples at group end
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pcts_channel #(
    parameter int ADC_W = pcts_pkg::PCTS_ADC_W,
    parameter int CNT_W = pcts_pkg::PCTS_CNT_W,
    parameter int DLY_W = pcts_pkg::PCTS_DLY_W,
    parameter int SAMPLE_NS = pcts_pkg::PCTS_TS_MID_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ADC_W-1:0] adc_sample,
    input wire logic adc_out_of_range,
    input wire logic [ADC_W-1:0] fast_filter,
    input wire logic event_written,
    input wire logic coincidence_result,
    output logic [ADC_W-1:0] decimated_sample,
    output logic decimated_valid,
    output logic shared_trigger,
    output logic pulse_accept,
    output pcts_pkg::pcts_probe_s probes
);
    import pcts_pkg::*;

    localparam int SUM_W = ADC_W + 6;

    logic [31:0] ctrl;
    logic [31:0] filt;
    logic [ADC_W-1:0] fast_trigger_level;
    logic [DLY_W-1:0] trigger_share_delay;
    logic [DLY_W-1:0] trigger_share_length;
    logic [DLY_W-1:0] local_processing_delay;
    logic [DLY_W-1:0] validation_stretch;
    pcts_run_e run_state;
    logic [CNT_W-1:0] channel_active_time;
    logic [CNT_W-1:0] trigger_count;
    logic [CNT_W-1:0] processed_event_count;
    logic [CNT_W-1:0] acquisition_time;
    logic [31:0] hi_latch;
    logic [SUM_W-1:0] acc;
    logic [5:0] dec_cnt;
    logic above;
    logic fast_trig;
    logic [DLY_W-1:0] sh_dly_cnt;
    logic [DLY_W-1:0] sh_len_cnt;
    logic sh_pend;
    logic [DLY_W-1:0] loc_cnt;
    logic loc_pend;
    logic [DLY_W-1:0] win_cnt;
    logic in_run;
    logic run_start;
    logic [PCTS_RANGE_W-1:0] range;
    logic [6:0] rise_steps;
    logic [6:0] flat_steps;
    logic filt_ok;
    logic [5:0] group_last;
    logic apb_wr;
    logic apb_rd;

    // filter range and timing sanity
    assign range = filt[2:0];
    assign rise_steps = filt[14:8];
    assign flat_steps = filt[22:16];
    assign filt_ok = (range >= PCTS_RANGE_MIN) && (range <= PCTS_RANGE_MAX)
        && ({1'b0, rise_steps} + {1'b0, flat_steps} <= {1'b0, PCTS_FILT_SUM_MAX}) // R2
        && (rise_steps >= PCTS_MIN_RISE) && (flat_steps >= PCTS_MIN_FLAT); // R3 R4
    assign group_last = 6'((1 << range) - 1);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign in_run = (run_state == PCTS_RUN);
    assign run_start = (run_state == PCTS_SETUP) && ctrl[PCTS_B_SETUP_DONE];
    assign above = fast_filter >= fast_trigger_level; // R20

    // apb slave: zero wait, all accesses answered in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > PCTS_A_ACQ_HI || paddr[1:0] != 2'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h0;
            filt <= 32'h0000_0301 | 32'h0000_0200;
            fast_trigger_level <= '1;
            trigger_share_delay <= '0;
            trigger_share_length <= DLY_W'(1);
            local_processing_delay <= '0;
            validation_stretch <= DLY_W'(1);
        end else if (apb_wr) begin
            unique case (paddr)
                PCTS_A_CTRL: ctrl <= pwdata; // R19
                PCTS_A_FILT: filt <= pwdata;
                PCTS_A_LEVEL: fast_trigger_level <= pwdata[ADC_W-1:0];
                PCTS_A_SHDLY: trigger_share_delay <= pwdata[DLY_W-1:0];
                PCTS_A_SHLEN: trigger_share_length <= pwdata[DLY_W-1:0];
                PCTS_A_LDLY: local_processing_delay <= pwdata[DLY_W-1:0];
                PCTS_A_VSTR: validation_stretch <= pwdata[DLY_W-1:0];
                default: ;
            endcase
        end
    end

    // reads in setup phase; low word latches high word for a torn-free pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            hi_latch <= 32'h0;
        end else if (apb_rd) begin
            prdata <= 32'h0;
            unique case (paddr)
                PCTS_A_CTRL: prdata <= ctrl;
                PCTS_A_FILT: prdata <= filt;
                PCTS_A_LEVEL: prdata <= 32'(fast_trigger_level);
                PCTS_A_SHDLY: prdata <= 32'(trigger_share_delay);
                PCTS_A_SHLEN: prdata <= 32'(trigger_share_length);
                PCTS_A_LDLY: prdata <= 32'(local_processing_delay);
                PCTS_A_VSTR: prdata <= 32'(validation_stretch);
                PCTS_A_STAT: prdata <= {28'h0, filt_ok, 3'(run_state)};
                PCTS_A_ACT_LO: begin
                    prdata <= channel_active_time[31:0]; // R21
                    hi_latch <= 32'(channel_active_time[CNT_W-1:32]);
                end
                PCTS_A_TRG_LO: begin
                    prdata <= trigger_count[31:0];
                    hi_latch <= 32'(trigger_count[CNT_W-1:32]);
                end
                PCTS_A_EVT_LO: begin
                    prdata <= processed_event_count[31:0];
                    hi_latch <= 32'(processed_event_count[CNT_W-1:32]);
                end
                PCTS_A_ACQ_LO: begin
                    prdata <= acquisition_time[31:0];
                    hi_latch <= 32'(acquisition_time[CNT_W-1:32]);
                end
                PCTS_A_ACT_HI, PCTS_A_TRG_HI, PCTS_A_EVT_HI, PCTS_A_ACQ_HI: prdata <= hi_latch;
                default: prdata <= 32'h0;
            endcase
        end
    end

    // run sequencing: setup phase excluded from all time counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state <= PCTS_IDLE;
        end else begin
            unique case (run_state)
                PCTS_IDLE: if (ctrl[PCTS_B_RUN_REQ]) run_state <= PCTS_SETUP;
                PCTS_SETUP: begin
                    if (!ctrl[PCTS_B_RUN_REQ]) run_state <= PCTS_IDLE;
                    else if (ctrl[PCTS_B_SETUP_DONE]) run_state <= PCTS_RUN;
                end
                PCTS_RUN: if (!ctrl[PCTS_B_RUN_REQ]) run_state <= PCTS_IDLE;
                default: run_state <= PCTS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_active_time <= '0;
            acquisition_time <= '0;
        end else if (run_start) begin
            channel_active_time <= '0;
            acquisition_time <= '0;
        end else if (in_run) begin
            acquisition_time <= acquisition_time + CNT_W'(SAMPLE_NS); // R10 R5
            if (!adc_out_of_range)
                channel_active_time <= channel_active_time + CNT_W'(SAMPLE_NS); // R6 R7
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_count <= '0;
            processed_event_count <= '0;
        end else if (run_start) begin
            trigger_count <= '0; // R9
            processed_event_count <= '0; // R11
        end else if (in_run) begin
            if (fast_trig && !adc_out_of_range) trigger_count <= trigger_count + CNT_W'(1); // R8
            if (event_written) processed_event_count <= processed_event_count + CNT_W'(1); // R11
        end
    end

    // decimation: accumulate 2^n samples then emit the average
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            dec_cnt <= '0;
            decimated_sample <= '0;
            decimated_valid <= 1'b0;
        end else begin
            decimated_valid <= 1'b0;
            if (dec_cnt >= group_last) begin
                decimated_sample <= ADC_W'((acc + SUM_W'(adc_sample)) >> range); // R1
                decimated_valid <= 1'b1; // R22
                acc <= '0;
                dec_cnt <= '0;
            end else begin
                acc <= acc + SUM_W'(adc_sample);
                dec_cnt <= dec_cnt + 6'h01;
            end
        end
    end

    // fast trigger edge on threshold crossing
    logic above_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            above_q <= 1'b0;
            fast_trig <= 1'b0;
        end else begin
            above_q <= above;
            fast_trig <= above && !above_q; // R20
        end
    end

    // shared trigger: delay then stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_pend <= 1'b0;
            sh_dly_cnt <= '0;
            sh_len_cnt <= '0;
            shared_trigger <= 1'b0;
        end else begin
            if (fast_trig && !sh_pend) begin
                sh_pend <= 1'b1;
                sh_dly_cnt <= trigger_share_delay;
            end else if (sh_pend && sh_dly_cnt != '0) begin
                sh_dly_cnt <= sh_dly_cnt - DLY_W'(1);
            end else if (sh_pend) begin
                sh_pend <= 1'b0;
                sh_len_cnt <= trigger_share_length; // R12
            end else if (sh_len_cnt != '0) begin
                sh_len_cnt <= sh_len_cnt - DLY_W'(1);
            end
            shared_trigger <= sh_len_cnt != '0; // R12
        end
    end

    // delayed local trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_pend <= 1'b0;
            loc_cnt <= '0;
            probes.delayed_trigger_probe <= 1'b0;
        end else begin
            probes.delayed_trigger_probe <= 1'b0;
            if (fast_trig && !loc_pend) begin
                loc_pend <= 1'b1;
                loc_cnt <= local_processing_delay; // R13
            end else if (loc_pend && loc_cnt != '0) begin
                loc_cnt <= loc_cnt - DLY_W'(1);
            end else if (loc_pend) begin
                loc_pend <= 1'b0;
                probes.delayed_trigger_probe <= 1'b1; // R18
            end
        end
    end

    // validation window and acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= '0;
            probes.validation_window_probe <= 1'b0;
            probes.acceptance_probe <= 1'b0;
            pulse_accept <= 1'b0;
        end else begin
            if (coincidence_result) win_cnt <= validation_stretch; // R16
            else if (win_cnt != '0) win_cnt <= win_cnt - DLY_W'(1);
            probes.validation_window_probe <= win_cnt != '0; // R16
            pulse_accept <= probes.delayed_trigger_probe && in_run
                && (!ctrl[PCTS_B_VALID_REQ] || probes.validation_window_probe); // R17 R19
            probes.acceptance_probe <= probes.delayed_trigger_probe && in_run
                && (!ctrl[PCTS_B_VALID_REQ] || probes.validation_window_probe); // R18
        end
    end

    property p_accept_needs_window;
        @(posedge pclk) disable iff (!presetn)
        pulse_accept && $past(ctrl[PCTS_B_VALID_REQ]) |-> $past(probes.validation_window_probe);
    endproperty
    a_accept_needs_window: assert property (p_accept_needs_window) // R17
        else $error("accepted pulse outside validation window");

    property p_window_opens;
        @(posedge pclk) disable iff (!presetn)
        coincidence_result && validation_stretch != '0 |-> ##2 probes.validation_window_probe;
    endproperty
    a_window_opens: assert property (p_window_opens) // R16
        else $error("validation window failed to open");

    property p_trig_clear;
        @(posedge pclk) disable iff (!presetn)
        run_start |=> trigger_count == '0 && processed_event_count == '0;
    endproperty
    a_trig_clear: assert property (p_trig_clear) // R9
        else $error("counters not cleared at run start");

    property p_active_pause;
        @(posedge pclk) disable iff (!presetn)
        in_run && adc_out_of_range && !run_start |=> $stable(channel_active_time);
    endproperty
    a_active_pause: assert property (p_active_pause) // R7
        else $error("active time ran while out of range");

    property p_acq_idle;
        @(posedge pclk) disable iff (!presetn)
        run_state == PCTS_SETUP && !run_start |=> $stable(acquisition_time);
    endproperty
    a_acq_idle: assert property (p_acq_idle) // R10
        else $error("acquisition time ran during setup");

    property p_trig_inc;
        @(posedge pclk) disable iff (!presetn)
        in_run && fast_trig && !adc_out_of_range && !run_start
            |=> trigger_count == $past(trigger_count) + CNT_W'(1);
    endproperty
    a_trig_inc: assert property (p_trig_inc) // R8
        else $error("trigger count missed a trigger");

    property p_dec_period;
        @(posedge pclk) disable iff (!presetn)
        decimated_valid && range == PCTS_RANGE_MIN ##1 range == PCTS_RANGE_MIN
            |=> decimated_valid;
    endproperty
    a_dec_period: assert property (p_dec_period) // R22
        else $error("decimated strobe period wrong");

    property p_evt_inc;
        @(posedge pclk) disable iff (!presetn)
        in_run && event_written && !run_start
            |=> processed_event_count == $past(processed_event_count) + CNT_W'(1);
    endproperty
    a_evt_inc: assert property (p_evt_inc) // R11
        else $error("event count missed an event");
endmodule : pcts_channel
`default_nettype wire

// file: rtl/pcts_pkg.sv
// package for the pulse channel timing and statistics block
package pcts_pkg;
    localparam int PCTS_CNT_W = 48;
    localparam int PCTS_DLY_W = 16;
    localparam int PCTS_ADC_W = 16;
    localparam int PCTS_ACC_W = 24;
    localparam int PCTS_RANGE_W = 3;
    localparam logic [PCTS_RANGE_W-1:0] PCTS_RANGE_MAX = 3'h6;
    localparam logic [PCTS_RANGE_W-1:0] PCTS_RANGE_MIN = 3'h1;
    localparam logic [6:0] PCTS_FILT_SUM_MAX = 7'h7F;
    localparam logic [6:0] PCTS_MIN_RISE = 7'h02;
    localparam logic [6:0] PCTS_MIN_FLAT = 7'h03;
    // sample period per converter variant, in ns
    localparam int PCTS_TS_FAST_NS = 2;
    localparam int PCTS_TS_MID_NS = 4;
    localparam int PCTS_TS_SLOW_NS = 10;
    localparam int PCTS_CLK_NS = 50;

    // register map, byte addresses
    localparam logic [7:0] PCTS_A_CTRL = 8'h00;
    localparam logic [7:0] PCTS_A_FILT = 8'h04;
    localparam logic [7:0] PCTS_A_LEVEL = 8'h08;
    localparam logic [7:0] PCTS_A_SHDLY = 8'h0C;
    localparam logic [7:0] PCTS_A_SHLEN = 8'h10;
    localparam logic [7:0] PCTS_A_LDLY = 8'h14;
    localparam logic [7:0] PCTS_A_VSTR = 8'h18;
    localparam logic [7:0] PCTS_A_STAT = 8'h1C;
    localparam logic [7:0] PCTS_A_ACT_LO = 8'h20;
    localparam logic [7:0] PCTS_A_ACT_HI = 8'h24;
    localparam logic [7:0] PCTS_A_TRG_LO = 8'h28;
    localparam logic [7:0] PCTS_A_TRG_HI = 8'h2C;
    localparam logic [7:0] PCTS_A_EVT_LO = 8'h30;
    localparam logic [7:0] PCTS_A_EVT_HI = 8'h34;
    localparam logic [7:0] PCTS_A_ACQ_LO = 8'h38;
    localparam logic [7:0] PCTS_A_ACQ_HI = 8'h3C;

    // control word bits
    localparam int PCTS_B_RUN_REQ = 0;
    localparam int PCTS_B_SETUP_DONE = 1;
    localparam int PCTS_B_VALID_REQ = 13;

    typedef enum logic [2:0] {
        PCTS_IDLE = 3'b001,
        PCTS_SETUP = 3'b010,
        PCTS_RUN = 3'b100
    } pcts_run_e;

    typedef struct packed {
        logic delayed_trigger_probe;
        logic validation_window_probe;
        logic acceptance_probe;
    } pcts_probe_s;
endpackage : pcts_pkg

// file: tb/pcts_central_model.sv
// behavioural model of the central logic that combines shared fast triggers
`timescale 1ns/1ps
`default_nettype none
module pcts_central_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] fast_triggers,
    input wire logic [1:0] contribution_mask,
    input wire logic [1:0] threshold,
    input wire logic and_mode,
    output logic coincidence_result
);
    logic [1:0] masked;
    logic [1:0] sum;
    logic hit;
    // triggers are gated by this channel's mask before any test
    assign masked = fast_triggers & contribution_mask;
    assign sum = {1'b0, masked[0]} + {1'b0, masked[1]};
    assign hit = and_mode ? (&(masked | ~contribution_mask)) & (|contribution_mask)
        : (sum >= threshold) && (threshold != 2'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coincidence_result <= 1'b0;
        end else begin
            coincidence_result <= hit;
        end
    end
endmodule : pcts_central_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the pulse channel timing and statistics block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
    import pcts_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] adc_sample = 16'h1000;
    logic [15:0] fast_filter = 16'h0000;
    logic [15:0] decimated_sample;
    logic adc_out_of_range = 1'b0;
    logic event_written = 1'b0;
    logic coincidence_result, decimated_valid, shared_trigger, pulse_accept;
    pcts_probe_s probes;
    logic nb_trig = 1'b0;
    logic cand = 1'b0;
    logic adc_alt = 1'b0;
    logic [1:0] cmask = 2'h0;
    logic [1:0] cthr = 2'h0;
    logic [31:0] r;
    logic e;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;

    pcts_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_sample(adc_sample), .adc_out_of_range(adc_out_of_range),
        .fast_filter(fast_filter), .event_written(event_written),
        .coincidence_result(coincidence_result), .decimated_sample(decimated_sample),
        .decimated_valid(decimated_valid), .shared_trigger(shared_trigger),
        .pulse_accept(pulse_accept), .probes(probes));
    pcts_central_model central (.pclk(pclk), .presetn(presetn),
        .fast_triggers({nb_trig, shared_trigger}), .contribution_mask(cmask),
        .threshold(cthr), .and_mode(cand), .coincidence_result(coincidence_result));

    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // alternating samples average to the midpoint for any even group
    always @(posedge pclk) if (adc_alt) adc_sample <= adc_sample ^ 16'h2000;

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask : rdc

    task automatic rd48(input logic [7:0] a, output logic [47:0] v);
        apb(1'b0, a, 32'h0);
        v[31:0] = r;
        apb(1'b0, a + 8'h04, 32'h0);
        v[47:32] = r[15:0];
    endtask : rd48

    task automatic fire(input logic nb, output int t_sh, output int w_sh, output int t_dp,
                        output int n_acc, output int w_win);
        {t_sh, w_sh, t_dp, n_acc, w_win} = '0;
        @(posedge pclk);
        fast_filter <= 16'h0200;
        nb_trig <= nb;
        for (int i = 1; i < 40; i++) begin
            @(posedge pclk);
            if (i == 2) fast_filter <= 16'h0000;
            if (i == 12) nb_trig <= 1'b0;
            #1;
            if (shared_trigger === 1'b1 && w_sh == 0) t_sh = i;
            if (shared_trigger === 1'b1) w_sh++;
            if (probes.delayed_trigger_probe === 1'b1) t_dp = i;
            if (pulse_accept === 1'b1 && probes.acceptance_probe === 1'b1) n_acc++;
            if (probes.validation_window_probe === 1'b1) w_win++;
        end
    endtask : fire

    task automatic s_reset();
        rdc(PCTS_A_CTRL, 32'h0);
        rdc(PCTS_A_FILT, 32'h0000_0301);
        rdc(PCTS_A_STAT, 32'h1);
        rdc(PCTS_A_SHLEN, 32'h1);
        rdc(PCTS_A_VSTR, 32'h1);
        rdc(PCTS_A_LDLY, 32'h0);
        apb(1'b1, 8'h40, 32'h5);
        `CHK(e, 1'b1)
        apb(1'b0, 8'h02, 32'h0);
        `CHK(({e, r}), ({1'b1, 32'h0}))
    endtask : s_reset

    task automatic s_filt();
        logic [31:0] fv [5] = '{32'h0003_0201, 32'h0003_0101, 32'h0002_0201,
            32'h0040_3F01, 32'h0040_4001};
        logic [4:0] okv = 5'h09;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, PCTS_A_FILT, fv[i]);
            apb(1'b0, PCTS_A_STAT, 32'h0);
            `CHK(r[3], okv[i])
        end
    endtask : s_filt

    task automatic s_decim();
        int t0;
        int n;
        adc_alt <= 1'b1;
        for (int k = 1; k < 7; k++) begin
            apb(1'b1, PCTS_A_FILT, {16'h0003, 8'h02, 5'h0, 3'(k)});
            repeat ((2 << k) + 4) @(posedge pclk);
            n = 0;
            t0 = 0;
            for (int i = 0; i < 200; i++) begin
                @(posedge pclk);
                #1;
                if (decimated_valid === 1'b1) begin
                    if (n > 0) `CHK(i - t0, 1 << k)
                    if (n > 0) `CHK(decimated_sample, 16'h2000)
                    t0 = i;
                    n++;
                end
            end
            `CHK(n > 2, 1'b1)
        end
        adc_alt <= 1'b0;
    endtask : s_decim

    task automatic s_run();
        logic [47:0] acq, act, v;
        int c0;
        apb(1'b1, PCTS_A_LEVEL, 32'h0100);
        apb(1'b1, PCTS_A_CTRL, 32'h1);
        apb(1'b0, PCTS_A_STAT, 32'h0);
        `CHK(r[2:0], 3'h2)
        apb(1'b1, PCTS_A_CTRL, 32'h3);
        apb(1'b0, PCTS_A_STAT, 32'h0);
        `CHK(r[2:0], 3'h4)
        repeat (3) begin
            @(posedge pclk);
            fast_filter <= 16'h0180;
            repeat (2) @(posedge pclk);
            fast_filter <= 16'h00FF;
            repeat (8) @(posedge pclk);
        end
        repeat (2) begin
            @(posedge pclk);
            event_written <= 1'b1;
            @(posedge pclk);
            event_written <= 1'b0;
        end
        adc_out_of_range <= 1'b1;
        repeat (10) @(posedge pclk);
        adc_out_of_range <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, PCTS_A_CTRL, 32'h0);
        apb(1'b0, PCTS_A_STAT, 32'h0);
        `CHK(r[2:0], 3'h1)
        rd48(PCTS_A_ACQ_LO, acq);
        rd48(PCTS_A_ACT_LO, act);
        `CHK(acq - act, 48'(10 * PCTS_TS_MID_NS))
        rd48(PCTS_A_TRG_LO, v);
        `CHK(v, 48'h3)
        rd48(PCTS_A_TRG_LO, v);
        `CHK(v, 48'h3)
        rd48(PCTS_A_EVT_LO, v);
        `CHK(v, 48'h2)
        apb(1'b1, PCTS_A_CTRL, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b1, PCTS_A_CTRL, 32'h3);
        c0 = cyc;
        rd48(PCTS_A_TRG_LO, v);
        `CHK(v, 48'h0)
        rd48(PCTS_A_EVT_LO, v);
        `CHK(v, 48'h0)
        apb(1'b1, PCTS_A_CTRL, 32'h0);
        c0 = (cyc - c0) * PCTS_TS_MID_NS;
        rd48(PCTS_A_ACQ_LO, acq);
        `CHK(acq + 48'h10 >= 48'(c0) && acq <= 48'(c0 + 4), 1'b1)
    endtask : s_run

    task automatic s_coinc();
        int t0, w, d0, n, wn, ts, dd;
        apb(1'b1, PCTS_A_SHLEN, 32'h4);
        apb(1'b1, PCTS_A_VSTR, 32'h8);
        apb(1'b1, PCTS_A_LDLY, 32'h4);
        apb(1'b1, PCTS_A_SHDLY, 32'h0);
        apb(1'b1, PCTS_A_CTRL, 32'h1);
        apb(1'b1, PCTS_A_CTRL, 32'h3);
        cmask <= 2'h1;
        cthr <= 2'h1;
        fire(1'b0, t0, w, d0, n, wn);
        `CHK(w, 4)
        // each of the 4 result cycles reloads the 8-cycle window
        `CHK(wn, 4 + 8 - 1)
        `CHK(n, 1)
        `CHK(d0 > 0, 1'b1)
        apb(1'b1, PCTS_A_SHDLY, 32'h5);
        fire(1'b0, ts, w, dd, n, wn);
        `CHK(ts - t0, 5)
        apb(1'b1, PCTS_A_SHDLY, 32'h0);
        apb(1'b1, PCTS_A_LDLY, 32'h9);
        fire(1'b0, ts, w, dd, n, wn);
        `CHK(dd - d0, 5)
        apb(1'b1, PCTS_A_LDLY, 32'h4);
        apb(1'b1, PCTS_A_CTRL, 32'h2003);
        cmask <= 2'h3;
        cthr <= 2'h2;
        fire(1'b0, ts, w, dd, n, wn);
        `CHK(({n, wn}), ({32'h0, 32'h0}))
        fire(1'b1, ts, w, dd, n, wn);
        `CHK(n, 1)
        apb(1'b1, PCTS_A_LDLY, 32'h14);
        fire(1'b1, ts, w, dd, n, wn);
        `CHK(n, 0)
        apb(1'b1, PCTS_A_LDLY, 32'h4);
        cand <= 1'b1;
        fire(1'b0, ts, w, dd, n, wn);
        `CHK(n, 0)
        fire(1'b1, ts, w, dd, n, wn);
        `CHK(n, 1)
    endtask : s_coinc

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_filt();
        s_decim();
        s_run();
        s_coinc();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
